//--- rtl/srpc_regs.svh
// timing counts and field positions for the refresh and power block
`ifndef SRPC_REGS_SVH
`define SRPC_REGS_SVH

// internal oscillator period
`define SRPC_CLK_PERIOD_NS 20
// whole array must be refreshed once per this period
`define SRPC_REFRESH_PERIOD_MS 64
// rows covered by the shared refresh counter
`define SRPC_ROW_COUNT 8192
`define SRPC_ROW_W 13
// distributed interval, longest time so it rounds down
`define SRPC_REF_INTERVAL_NS \
  ((`SRPC_REFRESH_PERIOD_MS * 1000000) / `SRPC_ROW_COUNT)
`define SRPC_REF_INTERVAL_CYC \
  (`SRPC_REF_INTERVAL_NS / `SRPC_CLK_PERIOD_NS)
// one internal refresh cycle, least time so it rounds up
`define SRPC_RFC_NS 70
`define SRPC_RFC_CYC \
  ((`SRPC_RFC_NS + `SRPC_CLK_PERIOD_NS - 1) / `SRPC_CLK_PERIOD_NS)
// least nop clocks after leaving self refresh
`define SRPC_XSR_MIN_CLKS 2
// address bit that selects all banks on precharge
`define SRPC_ALL_BANK_BIT 10
`define SRPC_ADDR_W 13
`define SRPC_BANKS 4

`endif

//--- rtl/srpc_pkg.sv
// types shared by the refresh and power control block
package srpc_pkg;

  // link side operating states
  typedef enum logic [2:0] {
    ST_RUN  = 3'b000,
    ST_SUSP = 3'b001,
    ST_PDN  = 3'b010,
    ST_SREF = 3'b011,
    ST_SREX = 3'b100
  } srpc_state_e;

  // command code {chip select low, ras, cas, we}
  typedef enum logic [3:0] {
    CMD_MRS = 4'h0,
    CMD_REF = 4'h1,
    CMD_PRE = 4'h2,
    CMD_ACT = 4'h3,
    CMD_WR  = 4'h4,
    CMD_RD  = 4'h5,
    CMD_BST = 4'h6,
    CMD_NOP = 4'h7
  } srpc_cmd_e;

endpackage : srpc_pkg

//--- rtl/srpc_refresh_engine.sv
// internal refresh engine on the device's own oscillator clock
`timescale 1ns/1ns
`include "srpc_regs.svh"

module srpc_refresh_engine #(
  parameter int ROW_W = `SRPC_ROW_W,
  parameter int INT_CYC = `SRPC_REF_INTERVAL_CYC,
  parameter int RFC_CYC = `SRPC_RFC_CYC
) (
  input wire logic clk, // internal oscillator
  input wire logic rst_n, // async reset, active low
  input wire logic ar_tgl, // auto refresh event, link domain toggle
  input wire logic sref_lvl, // self refresh level, link domain
  output logic busy_q, // refresh cycle in progress
  output logic ref_stb_q, // one cycle refresh strobe to the array
  output logic [ROW_W-1:0] ref_row_q // row refreshed at the strobe
);

  localparam int GAP_MAX = INT_CYC + RFC_CYC + 2;

  logic ar_s1_q, ar_s2_q, ar_s3_q;
  logic sr_s1_q, sr_s2_q;
  logic [15:0] tick_q;
  logic [15:0] busy_cnt_q;
  logic [ROW_W-1:0] row_cnt_q;
  logic ar_evt, sr_due, go;

  // crossings: first flop feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ar_s1_q <= 1'b0;
      ar_s2_q <= 1'b0;
      ar_s3_q <= 1'b0;
      sr_s1_q <= 1'b0;
      sr_s2_q <= 1'b0;
    end else begin
      ar_s1_q <= ar_tgl;
      ar_s2_q <= ar_s1_q;
      ar_s3_q <= ar_s2_q;
      sr_s1_q <= sref_lvl;
      sr_s2_q <= sr_s1_q;
    end
  end

  // one refresh per external command, timed ones in self refresh
  assign ar_evt = ar_s2_q ^ ar_s3_q;
  assign sr_due = sr_s2_q && (tick_q >= 16'(INT_CYC - 1)) &&
                  (busy_cnt_q == 16'h0);
  assign go = ar_evt || sr_due;

  // interval timer, idle and cleared outside self refresh
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tick_q <= 16'h0;
    else if (!sr_s2_q || go) tick_q <= 16'h0;
    else if (tick_q < 16'(INT_CYC - 1)) tick_q <= tick_q + 16'h1;
  end

  // busy is a flop so the link side never samples a glitch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_q <= 16'h0;
      busy_q <= 1'b0;
    end else begin
      if (go) busy_cnt_q <= 16'(RFC_CYC);
      else if (busy_cnt_q != 16'h0) busy_cnt_q <= busy_cnt_q - 16'h1;
      busy_q <= go || (busy_cnt_q > 16'h1);
    end
  end

  // one row counter serves both refresh kinds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      row_cnt_q <= '0;
      ref_row_q <= '0;
      ref_stb_q <= 1'b0;
    end else begin
      ref_stb_q <= go;
      if (go) begin
        ref_row_q <= row_cnt_q;
        row_cnt_q <= row_cnt_q + 1'b1;
      end
    end
  end

  // helper state for the checks below
  logic seen_q;
  logic [ROW_W-1:0] last_row_q;
  logic [15:0] gap_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
      last_row_q <= '0;
      gap_q <= 16'h0;
    end else begin
      if (ref_stb_q) seen_q <= 1'b1;
      if (ref_stb_q) last_row_q <= ref_row_q;
      if (!sr_s2_q || ref_stb_q) gap_q <= 16'h0;
      else gap_q <= gap_q + 16'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_row_step;
    (ref_stb_q && seen_q) |-> ref_row_q == ROW_W'(last_row_q + 1'b1);
  endproperty
  a_row_step: assert property (p_row_step)
    else $error("refresh row did not advance by one");

  property p_sr_self_timed;
    sr_s2_q |-> gap_q <= 16'(GAP_MAX);
  endproperty
  a_sr_self_timed: assert property (p_sr_self_timed)
    else $error("self refresh missed an internal refresh");

endmodule : srpc_refresh_engine

//--- rtl/srpc_top.sv
// refresh and low power state control of a four bank sdram
`timescale 1ns/1ns
`include "srpc_regs.svh"

// Overview of operation
// - refresh row from internal counter, address ignored
// - self refresh ignores all but clock enable
// - self refresh runs own clock and refreshes
// - both refresh kinds share one row counter
// - clock enable low with nop and no burst under way enters power-down
// - power-down kind follows open bank state
// - power-down disables all buffers but clock enable
// - nop with clock enable high leaves power-down
// - clock enable low during burst suspends clock
// - suspended edge ignores inputs, freezes burst
// - clock enable high resumes on next edge
// - precharge all bank bit overrides bank select
module srpc_top #(
  parameter int ADDR_W = `SRPC_ADDR_W,
  parameter int BANKS = `SRPC_BANKS,
  parameter int ROW_W = `SRPC_ROW_W,
  parameter int XSR_CLKS = `SRPC_XSR_MIN_CLKS
) (
  input wire logic clk, // internal oscillator, free running
  input wire logic rst_n, // async reset, active low
  input wire logic link_clk, // external memory clock
  input wire logic cke, // clock enable pin
  input wire logic cs_n, // chip select, active low
  input wire logic ras_n, // row strobe, active low
  input wire logic cas_n, // column strobe, active low
  input wire logic we_n, // write enable, active low
  input wire logic [ADDR_W-1:0] addr, // address pins
  input wire logic [1:0] ba, // bank_select_high, bank_select_low
  input wire logic col_busy, // column access or burst under way
  output logic cmd_valid_q, // command taken, one cycle
  output logic [3:0] cmd_code_q, // taken command code
  output logic [ADDR_W-1:0] cmd_addr_q, // taken address
  output logic [1:0] cmd_ba_q, // taken bank
  output logic burst_clk_en_q, // internal edge enable for burst logic
  output logic in_buf_en_q, // input buffer enable
  output logic out_buf_en_q, // output buffer enable
  output logic pd_active_q, // in active power-down
  output logic pd_precharge_q, // in precharge power-down
  output logic self_refresh_q, // in self refresh
  output logic [BANKS-1:0] bank_open_q, // bank holds an open row
  output logic refresh_busy, // internal refresh running, link view
  output logic ref_stb_q, // refresh strobe, internal clock
  output logic [ROW_W-1:0] ref_row_q // refreshed row, internal clock
);

  srpc_pkg::srpc_state_e st_q, st_d;
  logic cke_q;
  logic [3:0] cmd;
  logic is_nop, is_ref, is_pre, is_act, take;
  logic ar_tgl_q;
  logic bz_s1_q, bz_s2_q;
  logic eng_busy;
  logic [7:0] xsr_cnt_q;
  logic xsr_done;

  // command decode; chip select high is an inhibit
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign is_nop = cs_n || (cmd == srpc_pkg::CMD_NOP);
  assign is_ref = (cmd == srpc_pkg::CMD_REF);
  assign is_pre = (cmd == srpc_pkg::CMD_PRE);
  assign is_act = (cmd == srpc_pkg::CMD_ACT);

  // a command counts only if the previous edge saw clock enable high;
  // refresh with clock enable falling is self refresh, not a refresh
  assign take = (st_q == srpc_pkg::ST_RUN) && cke_q && !cs_n &&
                !(is_ref && !cke);
  assign xsr_done = (xsr_cnt_q >= 8'(XSR_CLKS - 1));
  assign refresh_busy = bz_s2_q;

  // next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      srpc_pkg::ST_RUN: begin
        if (!cke) begin
          if (!cs_n && is_ref) st_d = srpc_pkg::ST_SREF;
          else if (col_busy) st_d = srpc_pkg::ST_SUSP;
          else if (is_nop) st_d = srpc_pkg::ST_PDN;
        end
      end
      srpc_pkg::ST_SUSP: begin
        if (cke) st_d = srpc_pkg::ST_RUN;
      end
      srpc_pkg::ST_PDN: begin
        if (cke && is_nop) st_d = srpc_pkg::ST_RUN;
      end
      srpc_pkg::ST_SREF: begin
        if (cke) st_d = srpc_pkg::ST_SREX;
      end
      srpc_pkg::ST_SREX: begin
        // hold until the last internal refresh has drained
        if (xsr_done && !bz_s2_q) st_d = srpc_pkg::ST_RUN;
      end
      default: st_d = srpc_pkg::ST_RUN;
    endcase
  end

  // state and clock enable history
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= srpc_pkg::ST_RUN;
      cke_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cke_q <= cke;
    end
  end

  // exit clock count after self refresh
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) xsr_cnt_q <= 8'h0;
    else if (st_q != srpc_pkg::ST_SREX) xsr_cnt_q <= 8'h0;
    else if (!xsr_done) xsr_cnt_q <= xsr_cnt_q + 8'h1;
  end

  // forwarded command; address dropped on refresh
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_valid_q <= 1'b0;
      cmd_code_q <= srpc_pkg::CMD_NOP;
      cmd_addr_q <= '0;
      cmd_ba_q <= 2'h0;
    end else begin
      cmd_valid_q <= take;
      if (take) begin
        cmd_code_q <= cmd;
        cmd_addr_q <= is_ref ? '0 : addr;
        cmd_ba_q <= is_ref ? 2'h0 : ba;
      end
    end
  end

  // internal edge enable: a low sample freezes the next edge
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) burst_clk_en_q <= 1'b0;
    else burst_clk_en_q <= cke && (st_d == srpc_pkg::ST_RUN);
  end

  // buffers off in power-down and self refresh; clock enable stays live
  // since it is a bare port here. outputs stay driven while suspended
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_buf_en_q <= 1'b0;
      out_buf_en_q <= 1'b0;
    end else begin
      in_buf_en_q <= !(st_d inside {srpc_pkg::ST_PDN,
                                    srpc_pkg::ST_SREF});
      out_buf_en_q <= !(st_d inside {srpc_pkg::ST_PDN,
                                     srpc_pkg::ST_SREF});
    end
  end

  // power-down flavour chosen at entry from the open banks
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_active_q <= 1'b0;
      pd_precharge_q <= 1'b0;
    end else if (st_d != srpc_pkg::ST_PDN) begin
      pd_active_q <= 1'b0;
      pd_precharge_q <= 1'b0;
    end else if (st_q != srpc_pkg::ST_PDN) begin
      pd_active_q <= |bank_open_q;
      pd_precharge_q <= ~|bank_open_q;
    end
  end

  // per bank row state
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
        bank_open_q[b] <= 1'b0;
      end else if (take && is_act && ba == 2'(b)) begin
        bank_open_q[b] <= 1'b1;
      end else if (take && is_pre &&
                   (addr[`SRPC_ALL_BANK_BIT] || ba == 2'(b))) begin
        bank_open_q[b] <= 1'b0;
      end
    end
  end

  // events toward the refresh engine; toggle survives the crossing
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      ar_tgl_q <= 1'b0;
      self_refresh_q <= 1'b0;
    end else begin
      if (take && is_ref) ar_tgl_q <= ~ar_tgl_q;
      self_refresh_q <= (st_d == srpc_pkg::ST_SREF);
    end
  end

  // engine busy back into the link domain
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      bz_s1_q <= 1'b0;
      bz_s2_q <= 1'b0;
    end else begin
      bz_s1_q <= eng_busy;
      bz_s2_q <= bz_s1_q;
    end
  end

  // refresh runs on the internal clock so it survives a stopped link
  srpc_refresh_engine #(
    .ROW_W(ROW_W)
  ) u_engine (
    .clk(clk),
    .rst_n(rst_n),
    .ar_tgl(ar_tgl_q),
    .sref_lvl(self_refresh_q),
    .busy_q(eng_busy),
    .ref_stb_q(ref_stb_q),
    .ref_row_q(ref_row_q)
  );

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!rst_n);

  sequence s_sr_entry;
    (st_q == srpc_pkg::ST_RUN) && !cke && !cs_n && is_ref;
  endsequence

  sequence s_susp_low;
    (st_q == srpc_pkg::ST_RUN) && !cke && col_busy;
  endsequence

  sequence s_pd_wake;
    (st_q == srpc_pkg::ST_PDN) ##0 (cke && is_nop);
  endsequence

  property p_ref_addr;
    (take && is_ref) |=> cmd_valid_q && cmd_addr_q == '0 &&
                         cmd_ba_q == 2'h0;
  endproperty
  a_ref_addr: assert property (p_ref_addr)
    else $error("address forwarded on refresh");

  property p_sr_hold;
    s_sr_entry |=> (st_q == srpc_pkg::ST_SREF) && self_refresh_q
                   ##1 !cmd_valid_q;
  endproperty
  a_sr_hold: assert property (p_sr_hold)
    else $error("self refresh entry or input ignore failed");

  property p_sr_stay;
    ((st_q == srpc_pkg::ST_SREF) && !cke) |=>
      (st_q == srpc_pkg::ST_SREF) && !cmd_valid_q && !in_buf_en_q;
  endproperty
  a_sr_stay: assert property (p_sr_stay)
    else $error("left self refresh with clock enable low");

  property p_srex_len;
    $rose(st_q == srpc_pkg::ST_SREX) |-> (st_q == srpc_pkg::ST_SREX)[*2];
  endproperty
  a_srex_len: assert property (p_srex_len)
    else $error("self refresh exit shorter than two clocks");

  property p_pd_entry;
    ((st_q == srpc_pkg::ST_RUN) && !cke && is_nop && !col_busy) |=>
      (st_q == srpc_pkg::ST_PDN) && (pd_active_q || pd_precharge_q);
  endproperty
  a_pd_entry: assert property (p_pd_entry)
    else $error("power-down not entered");

  property p_pd_kind;
    (st_q == srpc_pkg::ST_PDN) |->
      pd_active_q == |bank_open_q && pd_precharge_q == !pd_active_q;
  endproperty
  a_pd_kind: assert property (p_pd_kind)
    else $error("power-down kind disagrees with bank state");

  property p_pd_bufs;
    (st_q inside {srpc_pkg::ST_PDN, srpc_pkg::ST_SREF}) |->
      !in_buf_en_q && !out_buf_en_q;
  endproperty
  a_pd_bufs: assert property (p_pd_bufs)
    else $error("buffers enabled in power-down");

  property p_pd_wake;
    s_pd_wake |=> (st_q == srpc_pkg::ST_RUN) && in_buf_en_q;
  endproperty
  a_pd_wake: assert property (p_pd_wake)
    else $error("power-down exit missed");

  property p_susp_entry;
    s_susp_low |=> (st_q == srpc_pkg::ST_SUSP) && out_buf_en_q;
  endproperty
  a_susp_entry: assert property (p_susp_entry)
    else $error("clock suspend not entered");

  property p_susp_freeze;
    s_susp_low |=> !burst_clk_en_q ##1 !cmd_valid_q;
  endproperty
  a_susp_freeze: assert property (p_susp_freeze)
    else $error("suspended edge not frozen");

  property p_susp_exit;
    ((st_q == srpc_pkg::ST_SUSP) && cke) |=>
      (st_q == srpc_pkg::ST_RUN) && burst_clk_en_q;
  endproperty
  a_susp_exit: assert property (p_susp_exit)
    else $error("clock suspend exit late");

  property p_pre_all;
    (take && is_pre && addr[`SRPC_ALL_BANK_BIT]) |=> bank_open_q == '0;
  endproperty
  a_pre_all: assert property (p_pre_all)
    else $error("precharge all left a bank open");

  property p_pre_one;
    (take && is_pre && !addr[`SRPC_ALL_BANK_BIT]) |=>
      bank_open_q == ($past(bank_open_q) &
                      ~(BANKS'(1) << $past(ba)));
  endproperty
  a_pre_one: assert property (p_pre_one)
    else $error("single bank precharge hit the wrong bank");

endmodule : srpc_top

//--- sim/srpc_ctrl_model.sv
// memory controller model that drives the command pins on the link clock
`timescale 1ns/1ns
module srpc_ctrl_model (
  input wire logic link_clk, // memory clock from the bench
  output logic cke, // clock enable pin
  output logic cs_n, // chip select, active low
  output logic ras_n, // row strobe, active low
  output logic cas_n, // column strobe, active low
  output logic we_n, // write enable, active low
  output logic [12:0] addr, // address pins
  output logic [1:0] ba // bank select
);
  // bus starts inhibited with cke low until the bench wakes the device
  initial begin
    cke = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    addr = 13'h0000;
    ba = 2'h0;
  end

  // one command for exactly one sampling edge, then inhibit again;
  // released address lines flip so a stale value never looks valid
  task automatic issue(input logic [3:0] code, input logic [12:0] a,
                       input logic [1:0] b, input logic ck);
    @(posedge link_clk);
    {cs_n, ras_n, cas_n, we_n} <= code;
    addr <= a;
    ba <= b;
    cke <= ck;
    @(posedge link_clk);
    cs_n <= 1'b1;
    addr <= ~a;
    ba <= ~b;
  endtask : issue

  // n edges of inhibit with cke held, for precharge, refresh and exit gaps
  task automatic gap(input int n);
    repeat (n) begin
      @(posedge link_clk);
      cs_n <= 1'b1;
      addr <= ~addr;
    end
  endtask : gap
endmodule : srpc_ctrl_model

//--- sim/sdram_refresh_power_control_tb_top.sv
// self-checking bench for the refresh and low power control block
`timescale 1ns/1ns
module sdram_refresh_power_control_tb_top;
  logic clk, link_clk, rst_n, col_busy, link_run;
  logic cke, cs_n, ras_n, cas_n, we_n, cmd_valid_q, burst_clk_en_q;
  logic in_buf_en_q, out_buf_en_q, pd_active_q, pd_precharge_q;
  logic self_refresh_q, refresh_busy, ref_stb_q;
  logic [12:0] addr, cmd_addr_q, ref_row_q;
  logic [1:0] ba, cmd_ba_q;
  logic [3:0] cmd_code_q, bank_open_q, exp_open;
  int err_count, n_checks, n_valid, n_stb, exp_row, cycles;

  srpc_ctrl_model ctrl (.link_clk(link_clk), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .ba(ba));

  srpc_top uut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
    .ba(ba), .col_busy(col_busy), .cmd_valid_q(cmd_valid_q),
    .cmd_code_q(cmd_code_q), .cmd_addr_q(cmd_addr_q), .cmd_ba_q(cmd_ba_q),
    .burst_clk_en_q(burst_clk_en_q), .in_buf_en_q(in_buf_en_q),
    .out_buf_en_q(out_buf_en_q), .pd_active_q(pd_active_q),
    .pd_precharge_q(pd_precharge_q), .self_refresh_q(self_refresh_q),
    .bank_open_q(bank_open_q), .refresh_busy(refresh_busy),
    .ref_stb_q(ref_stb_q), .ref_row_q(ref_row_q));

  // internal oscillator, 20 ns
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // link clock 6 ns, off phase; it can be stopped low in self refresh
  initial begin
    link_clk = 1'b0;
    link_run = 1'b1;
    #2;
    forever begin
      #3;
      if (link_run) link_clk = ~link_clk;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // taken commands counted on the low phase, where outputs have settled
  always @(negedge link_clk) begin
    if (cmd_valid_q === 1'b1) n_valid++;
  end

  // model of the shared row counter: each strobe is the next row
  always @(negedge clk) begin
    if (ref_stb_q === 1'b1) begin
      chk(ref_row_q, exp_row);
      exp_row = (exp_row + 1) % 8192;
      n_stb++;
    end
  end

  // hang guard, well above the thousand or so cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      $display("timeout at %0t", $time);
      tally_and_finish();
    end
  end

  // one command with cke high, then compare what was taken
  task automatic cmd_chk(input logic [3:0] code, input logic [12:0] a,
                         input logic [1:0] b, input int taken);
    int v0;
    v0 = n_valid;
    ctrl.issue(code, a, b, 1'b1);
    ctrl.gap(2);
    #1;
    chk(n_valid - v0, taken);
    chk(bank_open_q, exp_open);
    if (taken != 0) begin
      chk(cmd_code_q, code);
      chk(cmd_addr_q, code == 4'h1 ? 13'h0000 : a);
      chk(cmd_ba_q, code == 4'h1 ? 2'h0 : b);
    end
  endtask : cmd_chk

  // {active pd, precharge pd, self refresh, in buf, out buf}
  task automatic st_chk(input logic [4:0] exp);
    ctrl.gap(2);
    #1;
    chk({pd_active_q, pd_precharge_q, self_refresh_q, in_buf_en_q,
         out_buf_en_q}, exp);
  endtask : st_chk

  // bounded wait until n more strobes and the link view is idle
  task automatic ref_wait(input int s0, input int n);
    for (int k = 0; k < 80; k++) begin
      // look after the edge has settled, or a busy still in the
      // synchroniser reads as idle and the next refresh comes too soon
      #1;
      if (n_stb - s0 >= n && refresh_busy === 1'b0) break;
      ctrl.gap(1);
    end
    ctrl.gap(2);
    chk(n_stb - s0, n);
    chk(refresh_busy, 1'b0);
  endtask : ref_wait

  // main sequence
  initial begin
    int s0;
    rst_n = 1'b0;
    col_busy = 1'b0;
    exp_open = 4'h0;
    exp_row = 0;
    void'($urandom(95230));
    repeat (5) @(posedge clk);
    chk(cmd_code_q, 4'h7);
    chk({cmd_valid_q, self_refresh_q, bank_open_q, ref_stb_q}, 7'h00);
    rst_n <= 1'b1;
    ctrl.issue(4'hf, 13'($urandom), 2'($urandom), 1'b1);
    ctrl.gap(2);
    // open all four banks, then single and all-bank precharge
    for (int b = 0; b < 4; b++) begin
      exp_open[b] = 1'b1;
      cmd_chk(srpc_pkg::CMD_ACT, 13'($urandom), 2'(b), 1);
    end
    exp_open[2] = 1'b0;
    cmd_chk(srpc_pkg::CMD_PRE, 13'($urandom) & 13'h1bff, 2'h2, 1);
    exp_open = 4'h0;
    cmd_chk(srpc_pkg::CMD_PRE, 13'($urandom) | 13'h0400, 2'h1, 1);
    ctrl.gap(3);
    // three refreshes, each waited out before the next, random address ignored
    s0 = n_stb;
    for (int i = 0; i < 3; i++) begin
      cmd_chk(srpc_pkg::CMD_REF, 13'($urandom), 2'($urandom), 1);
      ref_wait(s0, i + 1);
    end
    // active power-down; a real command with cke high does not wake it
    exp_open[1] = 1'b1;
    cmd_chk(srpc_pkg::CMD_ACT, 13'($urandom), 2'h1, 1);
    ctrl.issue(srpc_pkg::CMD_NOP, 13'($urandom), 2'($urandom), 1'b0);
    st_chk(5'b10000);
    cmd_chk(srpc_pkg::CMD_ACT, 13'($urandom), 2'h3, 0);
    st_chk(5'b00011);
    chk(burst_clk_en_q, 1'b1);
    // precharge power-down entered by inhibit, left by nop
    exp_open = 4'h0;
    cmd_chk(srpc_pkg::CMD_PRE, 13'($urandom) | 13'h0400,
            2'($urandom), 1);
    ctrl.issue(4'hf, 13'($urandom), 2'($urandom), 1'b0);
    st_chk(5'b01000);
    ctrl.issue(srpc_pkg::CMD_NOP, 13'($urandom), 2'($urandom), 1'b1);
    st_chk(5'b00011);
    // clock suspend during a burst: command ignored, buffers kept
    exp_open[0] = 1'b1;
    cmd_chk(srpc_pkg::CMD_ACT, 13'($urandom), 2'h0, 1);
    @(posedge link_clk) col_busy <= 1'b1;
    // the edge that registers cke low still takes its nop; only the
    // suspended edges after it drop commands
    s0 = n_valid;
    ctrl.issue(srpc_pkg::CMD_NOP, 13'($urandom), 2'($urandom), 1'b0);
    ctrl.issue(srpc_pkg::CMD_ACT, 13'($urandom), 2'h2, 1'b0);
    ctrl.gap(2);
    #1;
    chk({burst_clk_en_q, out_buf_en_q, pd_active_q}, 3'b010);
    chk(n_valid - s0, 1);
    chk(bank_open_q, exp_open);
    ctrl.issue(srpc_pkg::CMD_NOP, 13'($urandom), 2'($urandom), 1'b1);
    ctrl.gap(2);
    #1;
    chk(burst_clk_en_q, 1'b1);
    @(posedge link_clk) col_busy <= 1'b0;
    exp_open = 4'h0;
    cmd_chk(srpc_pkg::CMD_PRE, 13'($urandom) | 13'h0400,
            2'($urandom), 1);
    ctrl.gap(3);
    // self refresh with the link clock stopped
    ctrl.issue(srpc_pkg::CMD_REF, 13'($urandom), 2'($urandom), 1'b0);
    st_chk(5'b00100);
    s0 = n_stb;
    @(negedge link_clk) link_run = 1'b0;
    #20000;
    chk(n_stb - s0 >= 2, 1);
    link_run = 1'b1;
    ctrl.gap(4);
    ctrl.issue(srpc_pkg::CMD_NOP, 13'($urandom), 2'($urandom), 1'b1);
    st_chk(5'b00011);
    ref_wait(n_stb, 0);
    ctrl.gap(4);
    // distributed refresh resumes on the same row counter
    s0 = n_stb;
    cmd_chk(srpc_pkg::CMD_REF, 13'($urandom), 2'($urandom), 1);
    ref_wait(s0, 1);
    tally_and_finish();
  end
endmodule : sdram_refresh_power_control_tb_top
